// ### hdl/tmr_defs.svh
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH
// Register addresses
`define TMR_ADDR_MODE    16'hFF86
`define TMR_ADDR_PRESC   16'hFF87
`define TMR_ADDR_CCC     16'hFF88
`define TMR_ADDR_OUTC    16'hFF89
// Mode control fields
`define TMR_MODE_OVF     0
`define TMR_MODE_TOG     1
`define TMR_MODE_OPLO    2
`define TMR_MODE_OPHI    3
`define TMR_MODE_MASK    8'h0F
// Capture/compare control fields
`define TMR_CCC_CAP0     0
`define TMR_CCC_TRIG0    1
`define TMR_CCC_CAP1     2
`define TMR_CCC_MASK     8'h07
// Output control fields
`define TMR_OUTC_OE      0
`define TMR_OUTC_INV0    1
`define TMR_OUTC_CLR     2
`define TMR_OUTC_SET     3
`define TMR_OUTC_INV1    4
`define TMR_OUTC_OSPE    5
`define TMR_OUTC_OSPT    6
`define TMR_OUTC_MASK    8'h33
// Prescaler fields
`define TMR_PRE_CLK_LO   0
`define TMR_PRE_E0_LO    4
`define TMR_PRE_E1_LO    6
`define TMR_PRE_MASK     8'hF3
// Reset values and counter maximum
`define TMR_RST_REG      8'h00
`define TMR_RST_CNT      16'h0000
`define TMR_CNT_MAX      16'hFFFF
`endif

// ### hdl/tmr_pkg.sv
package tmr_pkg;
   typedef enum logic [1:0] {
      TMR_OP_STOP  = 2'b00,
      TMR_OP_FREE  = 2'b01,
      TMR_OP_EDGE  = 2'b10,
      TMR_OP_MATCH = 2'b11
   } tmr_op_t;
   typedef enum logic [1:0] {
      TMR_EDGE_FALL = 2'b00,
      TMR_EDGE_RISE = 2'b01,
      TMR_EDGE_BAD  = 2'b10,
      TMR_EDGE_BOTH = 2'b11
   } tmr_edge_t;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic [7:0]  bit_mask;
   } tmr_bus_t;
   typedef struct packed {
      logic match0;
      logic match1;
      logic ovf;
   } tmr_irq_t;
endpackage

// ### hdl/tmr_ctrl.sv
`timescale 1ns/10ps
`include "tmr_defs.svh"
// Functional notes
// R1 - Op field: 00 stop and clear, 01 free, 10 edge restart, 11 match restart
// R2 - Counter starts when op field goes nonzero, stops when written 00
// R3 - Software leaves mode register alone while running, except stop or flag
// R4 - Mode control register resets to zero
// R5 - Output toggles on a match whose inversion enable is set; toggle bit adds first input edge
// R6 - Overflow flag set when counter wraps from all ones to zero
// R7 - Overflow flag cleared by writing 0 or stopping; writing 1 sets it
// R8 - Capture/compare control resets to zero; unchanged while running
// R9 - Register one control bit: 0 compare, 1 capture
// R10 - Register zero trigger: 0 second input edge, 1 reverse first edge
// R11 - Both-edge first input with reverse capture gives no valid edge
// R12 - Register zero control bit picks compare or capture; 0 in match mode
// R13 - Reverse capture: second input edge raises match zero irq, no capture
// R14 - Capture trigger pulses last longer than two count clocks
// R15 - While running only the trigger bits and register one inversion enable of output control written
// R16 - Register one inversion enable stays writable while running
// R17 - Output control register resets to zero
// R18 - Software sets inversions, then output enable, then one level trigger
// R19 - Mode control register takes single-bit and whole-byte writes
// R20 - Counter reads zero while stopped, else the live count
// R21 - Edge select: 00 falling, 01 rising, 11 both, 10 prohibited
// R22 - Unused upper bits of mode and capture control read zero
module tmr_ctrl #(
   parameter int CNT_W = 16
) (
   input  wire logic           clk,
   input  wire logic           rst,
   input  wire logic           ce,
   input  wire tmr_pkg::tmr_bus_t bus,
   output logic [7:0]          rdata,
   input  wire logic [CNT_W-1:0] cmp0_wdata,
   input  wire logic           cmp0_wr,
   input  wire logic [CNT_W-1:0] cmp1_wdata,
   input  wire logic           cmp1_wr,
   output logic [CNT_W-1:0]    count_register,
   output logic [CNT_W-1:0]    capcmp_zero,
   output logic [CNT_W-1:0]    capcmp_one,
   input  wire logic           first_input_pin,
   input  wire logic           second_input_pin,
   output logic                timer_out_pin,
   output tmr_pkg::tmr_irq_t   irq
);
   import tmr_pkg::*;

   // ****************************************
   // Registers and write decode
   // ****************************************
   logic [7:0]       timer_mode_control;
   logic [7:0]       capture_compare_control;
   logic [7:0]       timer_output_control;
   logic [7:0]       prescale_mode_reg;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] cap0;
   logic [CNT_W-1:0] cap1;
   logic             tout;
   logic [1:0]       pres_cnt_lo;
   logic [7:0]       pres_cnt;
   logic [1:0]       in0_sync;
   logic [1:0]       in1_sync;
   logic             in0_prev;
   logic             in1_prev;

   wire wr_mode  = ce && bus.wr && bus.addr == `TMR_ADDR_MODE;
   wire wr_presc = ce && bus.wr && bus.addr == `TMR_ADDR_PRESC;
   wire wr_ccc   = ce && bus.wr && bus.addr == `TMR_ADDR_CCC;
   wire wr_outc  = ce && bus.wr && bus.addr == `TMR_ADDR_OUTC;

   // Bit mask lets a single-bit write leave the other bits alone
   wire [7:0] mode_wr_val = (timer_mode_control & ~bus.bit_mask)
                           | (bus.wdata & bus.bit_mask);           // R19
   wire [7:0] ccc_wr_val  = (capture_compare_control & ~bus.bit_mask)
                           | (bus.wdata & bus.bit_mask);
   wire [7:0] outc_wr_val = (timer_output_control & ~bus.bit_mask)
                           | (bus.wdata & bus.bit_mask);
   wire [7:0] pre_wr_val  = (prescale_mode_reg & ~bus.bit_mask)
                           | (bus.wdata & bus.bit_mask);

   wire [1:0] op_field = timer_mode_control[`TMR_MODE_OPHI:`TMR_MODE_OPLO];
   wire [1:0] next_op  = mode_wr_val[`TMR_MODE_OPHI:`TMR_MODE_OPLO];
   tmr_op_t op;
   assign op = tmr_op_t'(op_field);
   wire running = op != TMR_OP_STOP;                                // R2
   wire stop_wr = wr_mode && next_op == 2'b00;

   wire toggle_condition      = timer_mode_control[`TMR_MODE_TOG];
   wire reg_zero_capture_sel  = capture_compare_control[`TMR_CCC_CAP0];
   wire reg_zero_trigger_sel  = capture_compare_control[`TMR_CCC_TRIG0];
   wire reg_one_capture_sel   = capture_compare_control[`TMR_CCC_CAP1];
   wire output_enable_bit     = timer_output_control[`TMR_OUTC_OE];
   wire invert_en_zero        = timer_output_control[`TMR_OUTC_INV0];
   wire invert_en_one         = timer_output_control[`TMR_OUTC_INV1];
   wire init_level_set        = wr_outc && outc_wr_val[`TMR_OUTC_SET];
   wire init_level_clear      = wr_outc && outc_wr_val[`TMR_OUTC_CLR];
   wire oneshot_sw_trigger    = wr_outc && outc_wr_val[`TMR_OUTC_OSPT];

   // ****************************************
   // Input synchronisers and edge detection
   // ****************************************
   wire in0 = in0_sync[1];
   wire in1 = in1_sync[1];
   wire in0_rise = in0 && !in0_prev;
   wire in0_fall = !in0 && in0_prev;
   wire in1_rise = in1 && !in1_prev;
   wire in1_fall = !in1 && in1_prev;

   tmr_edge_t first_edge_sel;
   tmr_edge_t second_edge_sel;
   assign first_edge_sel  =
      tmr_edge_t'(prescale_mode_reg[`TMR_PRE_E0_LO +: 2]);
   assign second_edge_sel =
      tmr_edge_t'(prescale_mode_reg[`TMR_PRE_E1_LO +: 2]);

   function automatic logic edge_hit(input tmr_edge_t sel,
                                     input logic rise,
                                     input logic fall);
      unique case (sel)                                             // R21
         TMR_EDGE_FALL: edge_hit = fall;
         TMR_EDGE_RISE: edge_hit = rise;
         TMR_EDGE_BOTH: edge_hit = rise | fall;
         default:       edge_hit = 1'b0;
      endcase
   endfunction

   // Reverse phase with both edges has no opposite edge left to use
   wire both_rev = first_edge_sel == TMR_EDGE_BOTH
                   && reg_zero_trigger_sel;                         // R11
   wire first_valid = running && !both_rev
                      && edge_hit(first_edge_sel, in0_rise, in0_fall);
   wire first_rev = running && reg_zero_trigger_sel && !both_rev
                    && edge_hit(first_edge_sel, in0_fall, in0_rise);
   wire second_valid = running
                       && edge_hit(second_edge_sel, in1_rise, in1_fall);

   // ****************************************
   // Count clock enable
   // ****************************************
   wire [1:0] clk_sel = prescale_mode_reg[`TMR_PRE_CLK_LO +: 2];
   wire tick = clk_sel == 2'b00 ? 1'b1 :
               clk_sel == 2'b01 ? pres_cnt_lo == 2'b11 :
               clk_sel == 2'b10 ? pres_cnt == 8'hFF :
               first_valid;

   // ****************************************
   // Match, capture and restart
   // ****************************************
   wire match0 = running && tick && !reg_zero_capture_sel
                 && cnt == capcmp_zero;                             // R12
   wire match1 = running && tick && !reg_one_capture_sel
                 && cnt == capcmp_one;                              // R9
   wire cap0_trig = running && reg_zero_capture_sel &&
                    (reg_zero_trigger_sel ? first_rev
                                          : second_valid);          // R10
   wire cap1_trig = running && reg_one_capture_sel && first_valid;  // R9
   wire ext_irq0  = reg_zero_trigger_sel && second_valid;           // R13

   wire restart = (op == TMR_OP_EDGE && first_valid)
                  || (op == TMR_OP_MATCH && match0)
                  || (oneshot_sw_trigger && running);               // R1
   wire wrap = running && tick && !restart
               && cnt == `TMR_CNT_MAX;                              // R6
   wire [CNT_W-1:0] next_cnt =
      !running ? CNT_W'(`TMR_RST_CNT) :                              // R1
      restart  ? CNT_W'(`TMR_RST_CNT) :
      tick     ? cnt + CNT_W'(1) : cnt;

   wire tog = (match0 && invert_en_zero) || (match1 && invert_en_one)
              || (toggle_condition && first_valid);                 // R5
   wire next_tout = init_level_set   ? 1'b1 :
                    init_level_clear ? 1'b0 :
                    tog              ? !tout : tout;

   // Write 1 sets, write 0 clears; hardware wrap wins over a clear
   wire next_ovf = wrap ? 1'b1 :                                    // R6
                   stop_wr ? 1'b0 :                                 // R7
                   wr_mode ? mode_wr_val[`TMR_MODE_OVF] :            // R7
                   timer_mode_control[`TMR_MODE_OVF];
   wire [7:0] next_mode = wr_mode
      ? {mode_wr_val[7:1] & 7'(`TMR_MODE_MASK >> 1), next_ovf}       // R22
      : {timer_mode_control[7:1], next_ovf};

   // Running: only trigger bits and register one inversion take effect
   wire [7:0] outc_keep = running ? 8'(1 << `TMR_OUTC_INV1) : 8'hFF;
   wire [7:0] next_outc = ((outc_wr_val & outc_keep)
                          | (timer_output_control & ~outc_keep))
                          & `TMR_OUTC_MASK;                          // R16

   // ****************************************
   // State update
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         timer_mode_control      <= `TMR_RST_REG;                    // R4
         capture_compare_control <= `TMR_RST_REG;                    // R8
         timer_output_control    <= `TMR_RST_REG;                    // R17
         prescale_mode_reg       <= `TMR_RST_REG;
         cnt                     <= CNT_W'(`TMR_RST_CNT);
         cap0                    <= CNT_W'(`TMR_RST_CNT);
         cap1                    <= CNT_W'(`TMR_RST_CNT);
         tout                    <= 1'b0;
         pres_cnt_lo             <= 2'b00;
         pres_cnt                <= 8'h00;
         in0_sync                <= 2'b00;
         in1_sync                <= 2'b00;
         in0_prev                <= 1'b0;
         in1_prev                <= 1'b0;
      end else if (ce) begin
         in0_sync <= {in0_sync[0], first_input_pin};
         in1_sync <= {in1_sync[0], second_input_pin};
         // Start samples level, so a high pin counts as a rising edge
         in0_prev <= running ? in0 : 1'b0;
         in1_prev <= running ? in1 : 1'b0;
         timer_mode_control <= next_mode;
         if (wr_ccc && !running) begin
            capture_compare_control <= ccc_wr_val & `TMR_CCC_MASK;   // R8
         end
         if (wr_presc && !running) begin
            prescale_mode_reg <= pre_wr_val & `TMR_PRE_MASK;
         end
         if (wr_outc) begin
            timer_output_control <= next_outc;                       // R15
         end
         cnt         <= next_cnt;                                    // R2
         pres_cnt_lo <= running ? pres_cnt_lo + 2'b01 : 2'b00;
         pres_cnt    <= running ? pres_cnt + 8'h01 : 8'h00;
         if (cmp0_wr) begin
            cap0 <= cmp0_wdata;
         end else if (cap0_trig) begin
            cap0 <= cnt;
         end
         if (cmp1_wr) begin
            cap1 <= cmp1_wdata;
         end else if (cap1_trig) begin
            cap1 <= cnt;
         end
         tout          <= next_tout;
      end
   end

   // ****************************************
   // Outputs and read mux
   // ****************************************
   assign count_register = running ? cnt : CNT_W'(`TMR_RST_CNT);     // R20
   assign capcmp_zero    = cap0;
   assign capcmp_one     = cap1;
   assign timer_out_pin  = output_enable_bit && tout;
   // Reverse-phase capture suppresses the capture interrupt itself
   assign irq.match0 = match0 || ext_irq0
                       || (cap0_trig && !reg_zero_trigger_sel);      // R13
   assign irq.match1 = match1 || cap1_trig;
   assign irq.ovf    = wrap;

   // Trigger bits always read back as zero
   wire [7:0] outc_rd = timer_output_control & `TMR_OUTC_MASK;
   always_comb begin
      unique case (bus.addr)
         `TMR_ADDR_MODE:  rdata = timer_mode_control & `TMR_MODE_MASK; // R22
         `TMR_ADDR_PRESC: rdata = prescale_mode_reg;
         `TMR_ADDR_CCC:   rdata = capture_compare_control
                                  & `TMR_CCC_MASK;                   // R22
         `TMR_ADDR_OUTC:  rdata = outc_rd;
         default:         rdata = 8'h00;
      endcase
   end
endmodule

// ### verif/tmr_ctrl_properties.sv
`timescale 1ns/10ps
`include "tmr_defs.svh"
module tmr_ctrl_properties #(
   parameter int CNT_W = 16
) (
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              ce,
   input wire tmr_pkg::tmr_bus_t bus,
   input wire logic [7:0]        rdata,
   input wire logic [CNT_W-1:0]  count_register,
   input wire logic [CNT_W-1:0]  capcmp_zero,
   input wire logic              timer_out_pin
);
   import tmr_pkg::*;
   // ****
   // Shadow of op field, count clock select and output enable
   // ****
   logic [1:0] op_sh;
   logic       oe_sh;
   logic [1:0] clk_sh;
   // Count checks only hold with the undivided count clock
   wire        presc_wr = ce && bus.wr && (bus.addr == `TMR_ADDR_PRESC)
                          && (op_sh == 2'b00);
   wire        rd_mode = (bus.addr == `TMR_ADDR_MODE);
   wire        rd_ccc  = (bus.addr == `TMR_ADDR_CCC);
   wire        mode_wr = ce && bus.wr && rd_mode;
   // Running writes to output enable are refused, so shadow ignores them
   wire        outc_wr = ce && bus.wr && (bus.addr == `TMR_ADDR_OUTC)
                         && (op_sh == 2'b00) && bus.bit_mask[0];
   wire [1:0]  next_op = (op_sh & ~bus.bit_mask[3:2])
                         | (bus.wdata[3:2] & bus.bit_mask[3:2]);
   always_ff @(posedge clk) begin
      if (rst) begin
         op_sh <= 2'b00;
         oe_sh <= 1'b0;
         clk_sh <= 2'b00;
      end else begin
         if (presc_wr) begin
            clk_sh <= (clk_sh & ~bus.bit_mask[1:0])
                      | (bus.wdata[1:0] & bus.bit_mask[1:0]);
         end
         if (mode_wr) begin
            op_sh <= next_op;
         end
         if (outc_wr) begin
            oe_sh <= bus.wdata[0];
         end
      end
   end
   // ****
   // Properties
   // ****
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   property p_mode_reset;
      $past(rst) && rd_mode |-> rdata == 8'h00;
   endproperty
   a_mode_reset: assert property (p_mode_reset)
      else $error("mode not clear after reset");
   property p_stop_zero;
      op_sh == 2'b00 |-> count_register == '0;
   endproperty
   a_stop_zero: assert property (p_stop_zero)
      else $error("count not zero while stopped");
   property p_count_step;
      clk_sh == 2'b00 && op_sh == 2'b01 && $past(op_sh) == 2'b01
         && $past(ce)
         |-> count_register == CNT_W'($past(count_register) + 1'b1);
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("free count did not step by one");
   property p_match_restart;
      clk_sh == 2'b00 && op_sh == 2'b11 && $past(op_sh) == 2'b11 && ce
         && count_register == capcmp_zero |-> ##[1:2] count_register == '0;
   endproperty
   a_match_restart: assert property (p_match_restart)
      else $error("no restart on match");
   property p_ccc_frozen;
      op_sh != 2'b00 && $past(op_sh) != 2'b00 && rd_ccc && $past(rd_ccc)
         |-> $stable(rdata);
   endproperty
   a_ccc_frozen: assert property (p_ccc_frozen)
      else $error("capture control changed while running");
   property p_mode_upper;
      rd_mode |-> rdata[7:4] == 4'h0;
   endproperty
   a_mode_upper: assert property (p_mode_upper)
      else $error("mode upper bits not zero");
   property p_stop_clear;
      mode_wr && bus.bit_mask == 8'hFF && bus.wdata == 8'h00
         |=> !rd_mode || !rdata[0];
   endproperty
   a_stop_clear: assert property (p_stop_clear)
      else $error("overflow flag kept after stop");
   property p_out_quiet;
      !oe_sh |-> !timer_out_pin;
   endproperty
   a_out_quiet: assert property (p_out_quiet)
      else $error("output active while disabled");
endmodule
bind tmr_ctrl tmr_ctrl_properties #(.CNT_W(CNT_W)) chk_u (
   .clk           (clk),
   .rst           (rst),
   .ce            (ce),
   .bus           (bus),
   .rdata         (rdata),
   .count_register(count_register),
   .capcmp_zero   (capcmp_zero),
   .timer_out_pin (timer_out_pin)
);

// ### verif/tmr_pins_model.sv
`timescale 1ns/10ps
module tmr_pins_model (
   input  wire logic clk,
   output logic      first_input_pin,
   output logic      second_input_pin
);
   // ****
   // Input pin pulses
   // ****
   initial begin
      first_input_pin = 1'b0;
      second_input_pin = 1'b0;
   end
   task automatic pulse(input logic sel);
      @(negedge clk);
      first_input_pin = !sel;
      second_input_pin = sel;
      // Four cycles high, well past the minimum trigger width
      repeat (4) @(negedge clk);
      first_input_pin = 1'b0;
      second_input_pin = 1'b0;
      repeat (4) @(negedge clk);
   endtask
endmodule

// ### verif/test_tmr_ctrl.sv
`timescale 1ns/10ps
`include "tmr_defs.svh"
module test_tmr_ctrl;
   import tmr_pkg::*;
   logic        clk, rst, ce, cmp0_wr, cmp1_wr, m0_seen, m1_seen, ovf_seen;
   logic        first_input_pin, second_input_pin, timer_out_pin;
   logic [7:0]  rdata;
   logic [15:0] cmp0_wdata, cmp1_wdata, count_register, n, mx, t;
   logic [15:0] capcmp_zero, capcmp_one;
   tmr_bus_t    bus;
   tmr_irq_t    irq;
   int          error_cnt = 0, num_checks = 0, cyc = 0, seed;
   tmr_ctrl dut_u (.clk(clk), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata),
      .cmp0_wdata(cmp0_wdata), .cmp0_wr(cmp0_wr), .cmp1_wdata(cmp1_wdata),
      .cmp1_wr(cmp1_wr), .count_register(count_register),
      .capcmp_zero(capcmp_zero), .capcmp_one(capcmp_one),
      .first_input_pin(first_input_pin), .second_input_pin(second_input_pin),
      .timer_out_pin(timer_out_pin), .irq(irq));
   tmr_pins_model pins_u (.clk(clk), .first_input_pin(first_input_pin),
      .second_input_pin(second_input_pin));
   // ****
   // Tasks
   // ****
   task chk(input logic [15:0] seen, input logic [15:0] exp, input string s);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t %s", $time, s);
      end
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
      // Idle edge first, so back-to-back writes never retoggle the strobe
      @(negedge clk);
      bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d, bit_mask: m};
      @(negedge clk);
      bus.wr = 1'b0;
   endtask
   task rd(input logic [15:0] a, input logic [7:0] e, input string s);
      @(negedge clk);
      bus.addr = a;
      #1;
      chk({8'h00, rdata}, {8'h00, e}, s);
   endtask
   task ldc(input logic [15:0] v);
      cmp0_wdata = v;
      cmp1_wdata = v;
      {cmp0_wr, cmp1_wr} = 2'b11;
      @(negedge clk);
      {cmp0_wr, cmp1_wr} = 2'b00;
   endtask
   task wrap_up;
      $display("errors %0d checks %0d", error_cnt, num_checks);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Sticky catch of the one-cycle irq pulse; also the hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (irq.match0 === 1'b1) m0_seen <= 1'b1;
      if (irq.match1 === 1'b1) m1_seen <= 1'b1;
      if (irq.ovf === 1'b1) ovf_seen <= 1'b1;
      if (cyc == 80000) begin
         error_cnt++;
         wrap_up();
      end
   end
   // ****
   // Main sequence
   // ****
   initial begin
      seed = 32'h36B8;
      {rst, ce, cmp0_wr, cmp1_wr, m0_seen, m1_seen, ovf_seen} = 7'b1100000;
      // Mode address held through reset gives the reset check a target
      bus = '{wr: 1'b0, rd: 1'b0, addr: `TMR_ADDR_MODE,
              wdata: 8'h00, bit_mask: 8'h00};
      cmp0_wdata = 16'h0000;
      cmp1_wdata = 16'h0000;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      rd(`TMR_ADDR_MODE, 8'h00, "mode reset");
      rd(`TMR_ADDR_CCC, 8'h00, "ccc reset");
      rd(`TMR_ADDR_OUTC, 8'h00, "outc reset");
      rd(16'hFFAA, 8'h00, "unmapped");
      wr(`TMR_ADDR_CCC, 8'hFF, 8'hFF);
      rd(`TMR_ADDR_CCC, 8'h07, "ccc bits");
      wr(`TMR_ADDR_MODE, 8'hFF, 8'h02);
      rd(`TMR_ADDR_MODE, 8'h02, "bit write");
      wr(`TMR_ADDR_MODE, 8'hF0, 8'hF0);
      rd(`TMR_ADDR_MODE, 8'h02, "mode bits");
      wr(`TMR_ADDR_CCC, 8'h00, 8'hFF);
      ldc(16'hFFF0);
      wr(`TMR_ADDR_PRESC, 8'h50, 8'hFF);
      wr(`TMR_ADDR_OUTC, 8'h12, 8'hFF);
      wr(`TMR_ADDR_OUTC, 8'h13, 8'hFF);
      wr(`TMR_ADDR_OUTC, 8'h1B, 8'hFF);
      chk(timer_out_pin, 1'b1, "level set");
      rd(`TMR_ADDR_OUTC, 8'h13, "outc");
      wr(`TMR_ADDR_MODE, 8'h0A, 8'hFF);
      repeat (20 + ($random(seed) & 31)) @(negedge clk);
      pins_u.pulse(1'b0);
      chk(count_register < 16'h0010, 1'b1, "edge restart");
      chk(timer_out_pin, 1'b0, "edge toggle");
      wr(`TMR_ADDR_OUTC, 8'h00, 8'h10);
      rd(`TMR_ADDR_OUTC, 8'h03, "outc running");
      wr(`TMR_ADDR_CCC, 8'h05, 8'hFF);
      rd(`TMR_ADDR_CCC, 8'h00, "ccc running");
      wr(`TMR_ADDR_MODE, 8'h00, 8'hFF);
      chk(count_register, 16'h0000, "stop");
      wr(`TMR_ADDR_MODE, 8'h04, 8'hFF);
      ce = 1'b0;
      repeat (3) @(negedge clk);
      ce = 1'b1;
      for (t = 16'h0000; t < 16'hFFFF && count_register !== 16'hFFFF; t++)
         @(negedge clk);
      @(negedge clk);
      rd(`TMR_ADDR_MODE, 8'h05, "overflow");
      chk(ovf_seen, 1'b1, "overflow irq");
      wr(`TMR_ADDR_MODE, 8'h00, 8'hFF);
      rd(`TMR_ADDR_MODE, 8'h00, "stop clear");
      // Flag set by a write from stop, then cleared by a single-bit write while running
      wr(`TMR_ADDR_MODE, 8'h05, 8'hFF);
      rd(`TMR_ADDR_MODE, 8'h05, "flag set");
      wr(`TMR_ADDR_MODE, 8'h04, 8'h01);
      rd(`TMR_ADDR_MODE, 8'h04, "flag clear");
      wr(`TMR_ADDR_MODE, 8'h00, 8'hFF);
      n = 16'h0005 + 16'($random(seed) & 31);
      ldc(n);
      wr(`TMR_ADDR_MODE, 8'h0C, 8'hFF);
      mx = 16'h0000;
      repeat (3 * n + 10) begin
         @(negedge clk);
         if (count_register > mx) mx = count_register;
      end
      chk(mx, n, "match restart");
      wr(`TMR_ADDR_MODE, 8'h00, 8'hFF);
      wr(`TMR_ADDR_CCC, 8'h07, 8'hFF);
      wr(`TMR_ADDR_MODE, 8'h04, 8'hFF);
      repeat (40) @(negedge clk);
      {m0_seen, m1_seen} = 2'b00;
      pins_u.pulse(1'b1);
      chk(m0_seen, 1'b1, "external irq");
      chk(capcmp_zero, n, "no capture");
      pins_u.pulse(1'b0);
      chk(capcmp_one != n, 1'b1, "capture one");
      chk(m1_seen, 1'b1, "capture irq one");
      chk(capcmp_zero != n, 1'b1, "reverse capture");
      wr(`TMR_ADDR_MODE, 8'h00, 8'hFF);
      wr(`TMR_ADDR_PRESC, 8'h70, 8'hFF);
      wr(`TMR_ADDR_CCC, 8'h07, 8'hFF);
      wr(`TMR_ADDR_MODE, 8'h06, 8'hFF);
      t = {15'h0000, timer_out_pin};
      // Two toggles would cancel, so the capture one register also tells
      mx = capcmp_one;
      pins_u.pulse(1'b0);
      chk(timer_out_pin, t, "both edges");
      chk(capcmp_one, mx, "both edges capture");
      wrap_up();
   end
endmodule
